// ===== inc/chan_cfg_pkg.sv
// Package: register map, reset values and carrier types of the channel configuration bank
//
// Functional notes
// - Sixteen high limits live at indices 0x040..0x05E step 2, 12 bits wide, reset 0x7FF.
// - Each high limit is used aligned to the top 12 bits of the 16-bit conversion result.
// - Sixteen low limits live at indices 0x060..0x07E step 2, 12 bits wide, reset zero.
// - Each low limit is used aligned to the top 12 bits of the conversion result.
// - Sixteen deadband values live at indices 0x080..0x09E step 2, 12 bits, reset 0x10.
// - Each deadband value is scaled like the top 12 bits of the conversion result.
// - Bits 15..12 of every limit and deadband register are read-only and read as zero.
// - Sixteen 16-bit zero trims live at indices 0x0A0..0x0BE step 2, reset zero.
// - Sixteen 16-bit scale trims live at indices 0x0C0..0x0DE step 2, reset 0x8000.
// - 128 byte-wide slot entries live at indices 0x100..0x17F, reset zero, bits 7..4 read-only.
// - Bits 3..0 of slot n select analog input k directly, 0x0 for input 0 up to 0xF for 15.
package chan_cfg_pkg;

	localparam int unsigned NUM_CH    = 16;
	localparam int unsigned NUM_SLOTS = 128;
	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned IDX_W     = 10;
	localparam int unsigned CH_W      = 4;
	localparam int unsigned SLOT_W    = 7;
	localparam int unsigned LIM_W     = 12;
	localparam int unsigned TRIM_W    = 16;
	localparam int unsigned SEL_W     = 4;
	localparam int unsigned RESULT_W  = 16;
	localparam int unsigned PAD_W     = RESULT_W - LIM_W;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] HIGH_FIRST  = 10'h040;
	localparam logic [IDX_W-1:0] HIGH_LAST   = 10'h05E;
	localparam logic [IDX_W-1:0] LOW_FIRST   = 10'h060;
	localparam logic [IDX_W-1:0] LOW_LAST    = 10'h07E;
	localparam logic [IDX_W-1:0] DB_FIRST    = 10'h080;
	localparam logic [IDX_W-1:0] DB_LAST     = 10'h09E;
	localparam logic [IDX_W-1:0] ZT_FIRST    = 10'h0A0;
	localparam logic [IDX_W-1:0] ZT_LAST     = 10'h0BE;
	localparam logic [IDX_W-1:0] ST_FIRST    = 10'h0C0;
	localparam logic [IDX_W-1:0] ST_LAST     = 10'h0DE;
	localparam logic [IDX_W-1:0] SLOT_FIRST  = 10'h100;
	localparam logic [IDX_W-1:0] SLOT_LAST   = 10'h17F;

	// Reset values
	localparam logic [LIM_W-1:0]  HIGH_RST = 12'h7FF;
	localparam logic [LIM_W-1:0]  LOW_RST  = 12'h000;
	localparam logic [LIM_W-1:0]  DB_RST   = 12'h010;
	localparam logic [TRIM_W-1:0] ZT_RST   = 16'h0000;
	localparam logic [TRIM_W-1:0] ST_RST   = 16'h8000;
	localparam logic [SEL_W-1:0]  SLOT_RST = 4'h0;

	// Per-channel settings as the alert and trim logic sees them
	typedef struct packed {
		logic [RESULT_W-1:0] high_limit;
		logic [RESULT_W-1:0] low_limit;
		logic [RESULT_W-1:0] deadband;
		logic [TRIM_W-1:0]   zero_trim;
		logic [TRIM_W-1:0]   scale_trim;
	} chan_cfg_t;

endpackage

// ===== core/field_reg.sv
// Module: one software-writable register field with byte-lane write strobes
module field_reg #(
	parameter int unsigned         W   = 16,
	parameter logic [W-1:0]        RST = '0
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              we,
	input  wire logic [1:0]        be,
	input  wire logic [W-1:0]      wdata,
	output logic      [W-1:0]      q
);

	// Only bits that exist are stored; wider write data is dropped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= RST;
		end else if (we) begin
			for (int i = 0; i < W; i++) begin
				if (be[i / 8]) begin
					q[i] <= wdata[i];
				end
			end
		end
	end

endmodule

// ===== core/slot_table.sv
// Module: sequence slot table, one write port and two registered read ports
module slot_table #(
	parameter int unsigned         DEPTH = 128,
	parameter int unsigned         AW    = 7,
	parameter int unsigned         DW    = 4
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              we,
	input  wire logic [AW-1:0]     waddr,
	input  wire logic [DW-1:0]     wdata,
	input  wire logic [AW-1:0]     ra_addr,
	output logic      [DW-1:0]     ra_data,
	input  wire logic [AW-1:0]     rb_addr,
	output logic      [DW-1:0]     rb_data
);

	logic [DW-1:0] mem_q [DEPTH];

	// Flop storage so every entry has a known reset value
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	// Read ports; a same-cycle write shows one cycle later
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ra_data <= '0;
			rb_data <= '0;
		end else begin
			ra_data <= mem_q[ra_addr];
			rb_data <= mem_q[rb_addr];
		end
	end

endmodule

// ===== core/chan_cfg_regs.sv
// Module: APB register bank with per-channel limits, trims and the sequence slot table
module chan_cfg_regs #(
	parameter int unsigned NUM_CH    = chan_cfg_pkg::NUM_CH,
	parameter int unsigned NUM_SLOTS = chan_cfg_pkg::NUM_SLOTS
) (
	input  wire logic                                   clk,
	input  wire logic                                   arst_n,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [chan_cfg_pkg::ADDR_W-1:0]        paddr,
	input  wire logic [31:0]                            pwdata,
	input  wire logic [3:0]                             pstrb,
	output logic      [31:0]                            prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	output chan_cfg_pkg::chan_cfg_t [NUM_CH-1:0]        chan_cfg,
	input  wire logic [chan_cfg_pkg::SLOT_W-1:0]        slot_rd_idx,
	output logic      [chan_cfg_pkg::SEL_W-1:0]         slot_rd_input
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_RESPOND
	} apb_state_t;

	typedef enum logic [2:0] {
		RG_NONE,
		RG_HIGH,
		RG_LOW,
		RG_DB,
		RG_ZT,
		RG_ST,
		RG_SLOT
	} region_t;

	apb_state_t                              state_q;
	region_t                                 region;
	logic [chan_cfg_pkg::IDX_W-1:0]          idx;
	logic [chan_cfg_pkg::CH_W-1:0]           chan;
	logic [chan_cfg_pkg::SLOT_W-1:0]         slot;
	logic                                    wr_fire;
	logic [31:0]                             rd_word;
	logic [chan_cfg_pkg::SEL_W-1:0]          slot_apb_data;
	logic [chan_cfg_pkg::LIM_W-1:0]          high_q [NUM_CH];
	logic [chan_cfg_pkg::LIM_W-1:0]          low_q  [NUM_CH];
	logic [chan_cfg_pkg::LIM_W-1:0]          db_q   [NUM_CH];
	logic [chan_cfg_pkg::TRIM_W-1:0]         zt_q   [NUM_CH];
	logic [chan_cfg_pkg::TRIM_W-1:0]         st_q   [NUM_CH];
	logic [31:0]                             prdata_q;
	logic                                    pready_q;
	logic                                    pslverr_q;

	// Word index and the sub-fields that pick channel and slot
	assign idx  = paddr[chan_cfg_pkg::ADDR_W-1:2];
	assign chan = idx[chan_cfg_pkg::CH_W:1];
	assign slot = idx[chan_cfg_pkg::SLOT_W-1:0];

	// Address decode; odd indices inside a limit, deadband or trim bank and unaligned bytes are unmapped
	always_comb begin
		region = RG_NONE;
		if (paddr[1:0] != 2'b00) begin
			region = RG_NONE;
		end else if (idx >= chan_cfg_pkg::HIGH_FIRST && idx <= chan_cfg_pkg::HIGH_LAST
				&& !idx[0]) begin
			region = RG_HIGH;
		end else if (idx >= chan_cfg_pkg::LOW_FIRST && idx <= chan_cfg_pkg::LOW_LAST
				&& !idx[0]) begin
			region = RG_LOW;
		end else if (idx >= chan_cfg_pkg::DB_FIRST && idx <= chan_cfg_pkg::DB_LAST
				&& !idx[0]) begin
			region = RG_DB;
		end else if (idx >= chan_cfg_pkg::ZT_FIRST && idx <= chan_cfg_pkg::ZT_LAST
				&& !idx[0]) begin
			region = RG_ZT;
		end else if (idx >= chan_cfg_pkg::ST_FIRST && idx <= chan_cfg_pkg::ST_LAST
				&& !idx[0]) begin
			region = RG_ST;
		end else if (idx >= chan_cfg_pkg::SLOT_FIRST && idx <= chan_cfg_pkg::SLOT_LAST) begin
			region = RG_SLOT;
		end
	end

	// A write lands only at the edge where the master sees pready high
	assign wr_fire = (state_q == ST_RESPOND) && psel && penable && pwrite
			&& (region != RG_NONE);

	// Per-channel storage; limits keep only 12 bits so the top nibble cannot be written
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
		logic sel_ch;
		assign sel_ch = wr_fire && (chan == chan_cfg_pkg::CH_W'(ch));

		field_reg #(
			.W     (chan_cfg_pkg::LIM_W),
			.RST   (chan_cfg_pkg::HIGH_RST)
		) u_high (
			.clk   (clk),
			.arst_n(arst_n),
			.we    (sel_ch && region == RG_HIGH),
			.be    (pstrb[1:0]),
			.wdata (pwdata[chan_cfg_pkg::LIM_W-1:0]),
			.q     (high_q[ch])
		);

		field_reg #(
			.W     (chan_cfg_pkg::LIM_W),
			.RST   (chan_cfg_pkg::LOW_RST)
		) u_low (
			.clk   (clk),
			.arst_n(arst_n),
			.we    (sel_ch && region == RG_LOW),
			.be    (pstrb[1:0]),
			.wdata (pwdata[chan_cfg_pkg::LIM_W-1:0]),
			.q     (low_q[ch])
		);

		field_reg #(
			.W     (chan_cfg_pkg::LIM_W),
			.RST   (chan_cfg_pkg::DB_RST)
		) u_db (
			.clk   (clk),
			.arst_n(arst_n),
			.we    (sel_ch && region == RG_DB),
			.be    (pstrb[1:0]),
			.wdata (pwdata[chan_cfg_pkg::LIM_W-1:0]),
			.q     (db_q[ch])
		);

		field_reg #(
			.W     (chan_cfg_pkg::TRIM_W),
			.RST   (chan_cfg_pkg::ZT_RST)
		) u_zt (
			.clk   (clk),
			.arst_n(arst_n),
			.we    (sel_ch && region == RG_ZT),
			.be    (pstrb[1:0]),
			.wdata (pwdata[chan_cfg_pkg::TRIM_W-1:0]),
			.q     (zt_q[ch])
		);

		field_reg #(
			.W     (chan_cfg_pkg::TRIM_W),
			.RST   (chan_cfg_pkg::ST_RST)
		) u_st (
			.clk   (clk),
			.arst_n(arst_n),
			.we    (sel_ch && region == RG_ST),
			.be    (pstrb[1:0]),
			.wdata (pwdata[chan_cfg_pkg::TRIM_W-1:0]),
			.q     (st_q[ch])
		);

		// Limits and deadband shifted up so they compare against the result's top bits
		assign chan_cfg[ch].high_limit = {high_q[ch], {chan_cfg_pkg::PAD_W{1'b0}}};
		assign chan_cfg[ch].low_limit  = {low_q[ch], {chan_cfg_pkg::PAD_W{1'b0}}};
		assign chan_cfg[ch].deadband   = {db_q[ch], {chan_cfg_pkg::PAD_W{1'b0}}};
		assign chan_cfg[ch].zero_trim  = zt_q[ch];
		assign chan_cfg[ch].scale_trim = st_q[ch];
	end

	// Slot table; reserved upper nibble is never stored, lane 0 carries the select
	slot_table #(
		.DEPTH  (NUM_SLOTS),
		.AW     (chan_cfg_pkg::SLOT_W),
		.DW     (chan_cfg_pkg::SEL_W)
	) u_slots (
		.clk    (clk),
		.arst_n (arst_n),
		.we     (wr_fire && region == RG_SLOT && pstrb[0]),
		.waddr  (slot),
		.wdata  (pwdata[chan_cfg_pkg::SEL_W-1:0]),
		.ra_addr(slot),
		.ra_data(slot_apb_data),
		.rb_addr(slot_rd_idx),
		.rb_data(slot_rd_input)
	);

	// Read mux; unused upper bits, including reserved fields, read as zero
	always_comb begin
		rd_word = '0;
		case (region)
			RG_HIGH: rd_word[chan_cfg_pkg::LIM_W-1:0] = high_q[chan];
			RG_LOW:  rd_word[chan_cfg_pkg::LIM_W-1:0] = low_q[chan];
			RG_DB:   rd_word[chan_cfg_pkg::LIM_W-1:0] = db_q[chan];
			RG_ZT:   rd_word[chan_cfg_pkg::TRIM_W-1:0] = zt_q[chan];
			RG_ST:   rd_word[chan_cfg_pkg::TRIM_W-1:0] = st_q[chan];
			RG_SLOT: rd_word[chan_cfg_pkg::SEL_W-1:0] = slot_apb_data;
			default: rd_word = '0;
		endcase
	end

	// APB handshake; one wait state lets the slot table read settle into a flop
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q   <= ST_IDLE;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					pready_q  <= 1'b0;
					pslverr_q <= 1'b0;
					if (psel && !penable) begin
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
					pready_q  <= 1'b1;
					pslverr_q <= (region == RG_NONE);
					state_q   <= ST_RESPOND;
				end
				ST_RESPOND: begin
					pready_q  <= 1'b0;
					pslverr_q <= 1'b0;
					state_q   <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

endmodule

// ===== test/chan_cfg_checker.sv
// Checker: bus timing and field assertions for the channel configuration bank
module chan_cfg_checker #(
	parameter int unsigned NUM_CH    = 16,
	parameter int unsigned NUM_SLOTS = 128
) (
	input wire logic                              clk,
	input wire logic                              arst_n,
	input wire logic                              psel,
	input wire logic                              penable,
	input wire logic                              pwrite,
	input wire logic [11:0]                       paddr,
	input wire logic [31:0]                       pwdata,
	input wire logic [3:0]                        pstrb,
	input wire logic [31:0]                       prdata,
	input wire logic                              pready,
	input wire logic                              pslverr,
	input wire chan_cfg_pkg::chan_cfg_t [NUM_CH-1:0] chan_cfg,
	input wire logic [6:0]                        slot_rd_idx,
	input wire logic [3:0]                        slot_rd_input
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pad_or;

	// Pad nibbles under every aligned field; one flag saves forty-eight assertions
	always_comb begin
		pad_or = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			pad_or = pad_or | (|chan_cfg[i].high_limit[3:0]) | (|chan_cfg[i].low_limit[3:0]);
			pad_or = pad_or | (|chan_cfg[i].deadband[3:0]);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Handshake shape
	chk_access_timing: assert property (psel && !penable |-> ##2 (pready && psel && penable))
		else $error("pready not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error answer malformed");
	chk_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
		else $error("read data on write");
	// Address decode
	chk_outside_err: assert property (pready && (paddr[1:0] != 2'b00 || paddr > 12'h5FC) |-> pslverr)
		else $error("unmapped address accepted");
	chk_odd_index: assert property (pready && paddr >= 12'h100 && paddr < 12'h380 && paddr[2] |-> pslverr)
		else $error("odd index accepted");
	// Reserved bits, alignment and trim update
	chk_field_rsvd: assert property (pready && !pwrite && paddr < 12'h280 |-> prdata[31:12] == 20'h0_0000)
		else $error("limit reserved bits set");
	chk_slot_rsvd: assert property (pready && !pwrite && paddr[11:9] == 3'b010 |-> prdata[31:4] == 28'h000_0000)
		else $error("slot reserved bits set");
	chk_pad_clear: assert property (!pad_or)
		else $error("aligned field pad not zero");
	chk_trim_update: assert property (pready && pwrite && paddr == 12'h280 && pstrb[1:0] == 2'b11
		|=> chan_cfg[0].zero_trim == $past(pwdata[15:0]))
		else $error("zero trim not updated");
	// Read data and the exported settings must agree
	chk_high_mirror: assert property (pready && !pwrite && paddr == 12'h100
		|-> prdata[11:0] == chan_cfg[0].high_limit[15:4])
		else $error("high limit export differs from read");
	chk_scale_mirror: assert property (pready && !pwrite && paddr == 12'h378
		|-> prdata[15:0] == chan_cfg[15].scale_trim)
		else $error("scale trim export differs from read");

	cover property (pready && pwrite && !pslverr);
	cover property (pready && !pwrite && !pslverr);
	cover property (pslverr);
endmodule

// ===== test/chan_cfg_regs_test.sv
// Testbench: directed register scenarios for the channel configuration bank
module chan_cfg_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                              clk         = 1'b0;
	logic                              arst_n      = 1'b0;
	logic                              psel        = 1'b0;
	logic                              penable     = 1'b0;
	logic                              pwrite      = 1'b0;
	logic [11:0]                       paddr       = 12'h000;
	logic [31:0]                       pwdata      = 32'h0000_0000;
	logic [3:0]                        pstrb       = 4'h0;
	logic [6:0]                        slot_rd_idx = 7'h00;
	logic [31:0]                       prdata;
	logic                              pready;
	logic                              pslverr;
	logic [3:0]                        slot_rd_input;
	chan_cfg_pkg::chan_cfg_t [15:0]    chan_cfg;
	logic [31:0]                       rd;
	logic                              er;
	int                                bad_count   = 0;
	int                                cmp_count   = 0;

	chan_cfg_regs uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chan_cfg(chan_cfg),
		.slot_rd_idx(slot_rd_idx), .slot_rd_input(slot_rd_input));

	// 100 MHz clock
	always #5 clk = ~clk;

	task automatic final_report();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One transfer; bounded wait so a missing pready shows as a mismatch
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		cmp({31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		cmp(rd, exp);
		cmp({31'h0, er}, {31'h0, e});
	endtask

	function automatic logic [11:0] ca(input logic [11:0] b, input int c);
		return b + 12'(8 * c);
	endfunction

	task automatic t_reset();
		for (int c = 0; c < 16; c++) begin
			rchk(ca(12'h100, c), 32'h0000_07FF, 1'b0);
			rchk(ca(12'h180, c), 32'h0000_0000, 1'b0);
			rchk(ca(12'h200, c), 32'h0000_0010, 1'b0);
			rchk(ca(12'h280, c), 32'h0000_0000, 1'b0);
			rchk(ca(12'h300, c), 32'h0000_8000, 1'b0);
			cmp({16'h0, chan_cfg[c].high_limit}, 32'h0000_7FF0);
			cmp({16'h0, chan_cfg[c].deadband}, 32'h0000_0100);
			cmp({16'h0, chan_cfg[c].low_limit}, 32'h0000_0000);
			cmp({16'h0, chan_cfg[c].zero_trim}, 32'h0000_0000);
			cmp({16'h0, chan_cfg[c].scale_trim}, 32'h0000_8000);
		end
		rchk(12'h5FC, 32'h0000_0000, 1'b0);
	endtask

	// All-ones writes probe the reserved nibble; a lane-0 write keeps lane 1
	task automatic t_limits();
		wr(12'h118, 32'hFFFF_FFFF);
		wr(12'h198, 32'hFFFF_FFFF);
		wr(12'h218, 32'hFFFF_FFFF);
		rchk(12'h118, 32'h0000_0FFF, 1'b0);
		rchk(12'h198, 32'h0000_0FFF, 1'b0);
		rchk(12'h218, 32'h0000_0FFF, 1'b0);
		cmp({16'h0, chan_cfg[3].high_limit}, 32'h0000_FFF0);
		cmp({16'h0, chan_cfg[3].low_limit}, 32'h0000_FFF0);
		cmp({16'h0, chan_cfg[3].deadband}, 32'h0000_FFF0);
		apb(1'b1, 12'h178, 32'h0000_0A5C, 4'h1);
		rchk(12'h178, 32'h0000_075C, 1'b0);
		// Lane 1 alone; its reserved nibble must still be dropped
		apb(1'b1, 12'h178, 32'h0000_F300, 4'h2);
		rchk(12'h178, 32'h0000_035C, 1'b0);
		wr(12'h280, 32'hFFFF_1234);
		wr(12'h378, 32'h0000_FEDC);
		rchk(12'h280, 32'h0000_1234, 1'b0);
		rchk(12'h378, 32'h0000_FEDC, 1'b0);
		cmp({16'h0, chan_cfg[0].zero_trim}, 32'h0000_1234);
		cmp({16'h0, chan_cfg[15].scale_trim}, 32'h0000_FEDC);
	endtask

	// Every input code into slots 7, 15 .. 127, reserved bits written high
	task automatic t_slots();
		for (int k = 0; k < 16; k++) begin
			wr(12'h41C + 12'(32 * k), {28'h000_000F, 4'(k)});
			rchk(12'h41C + 12'(32 * k), {28'h0, 4'(k)}, 1'b0);
			slot_rd_idx <= 7'(8 * k + 7);
			repeat (2) @(posedge clk);
			cmp({28'h0, slot_rd_input}, {28'h0, 4'(k)});
		end
		// Lane 0 strobe low: the slot entry must keep its value
		apb(1'b1, 12'h41C, 32'h0000_0009, 4'hE);
		rchk(12'h41C, 32'h0000_0000, 1'b0);
	endtask

	task automatic t_unmapped();
		logic [11:0] bad [6] = '{12'h104, 12'h37C, 12'h380, 12'h600, 12'h101, 12'h000};
		foreach (bad[i]) begin
			wr(bad[i], 32'hFFFF_FFFF);
			cmp({31'h0, er}, 32'h1);
			rchk(bad[i], 32'h0000_0000, 1'b1);
		end
		rchk(12'h100, 32'h0000_07FF, 1'b0);
	endtask

	// Mid-run reset right after a write; zero trim, high limit, scale trim and slot banks must return to reset values
	task automatic t_rerst();
		wr(12'h280, 32'h0000_5555);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		cmp({16'h0, chan_cfg[0].zero_trim}, 32'h0000_0000);
		cmp({28'h0, slot_rd_input}, 32'h0000_0000);
		arst_n <= 1'b1;
		rchk(12'h280, 32'h0000_0000, 1'b0);
		rchk(12'h118, 32'h0000_07FF, 1'b0);
		rchk(12'h41C, 32'h0000_0000, 1'b0);
		cmp({16'h0, chan_cfg[15].scale_trim}, 32'h0000_8000);
		cmp({28'h0, slot_rd_input}, 32'h0000_0000);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_limits();
		t_slots();
		t_unmapped();
		t_rerst();
		final_report();
	end

	// Watchdog well past the expected few hundred cycles
	initial begin
		#200000;
		bad_count++;
		final_report();
	end
endmodule

bind chan_cfg_regs chan_cfg_checker #(.NUM_CH(NUM_CH), .NUM_SLOTS(NUM_SLOTS)) chk_i (
	.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .chan_cfg(chan_cfg), .slot_rd_idx(slot_rd_idx),
	.slot_rd_input(slot_rd_input));
